// >>> rtl/adc_result_store.sv
/*
 * Converter result storage, completion flag and conversion clock prescaler,
 * with an APB register slave and a masked level interrupt.
 * Assumes the converter core runs on i_clk_sys, takes o_conv_clk_en as its
 * conversion clock enable and hands each result over as a one-cycle pulse.
 */
// The implementer's own choices: the address map and the APB interface to the registers.
// Functional notes
// - Conversion clock enable is fc divided by 1, 2, 4, 8 or 16.
// - Each result is split over an upper and lower register; eight pairs.
// - Outside fixed repeat mode, channel n goes to pair n modulo 8.
// - Fixed repeat, interval every one: results always go to pair 0.
// - Fixed repeat, interval every four: results go to pairs 0 to 3.
// - Fixed repeat, interval every eight: results go to pairs 0 to 7.
// - End flag rises only together with or after the result store.
// - Lower register carries overrun and stored flags; 0 and 1 mean good.
// - Reading the end flag clears it.
// - Interval field: 00 every one, 01 every four, 10 every eight.
// - After the last pair of a group, storing wraps to pair 0.
module adc_result_store
   import adc_store_pkg::*;
#(
   parameter int CHAN_W = 5
) (
   input  wire logic                       i_clk_sys,
   input  wire logic                       i_rstn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       i_conv_valid,
   input  wire logic [adc_store_pkg::RES_W-1:0] i_conv_data,
   input  wire logic [CHAN_W-1:0]          i_conv_channel,
   input  wire logic                       i_conv_last,
   output logic                            o_conv_clk_en,
   output logic                            o_repeat,
   output logic                            o_scan,
   output logic                            o_conv_done_irq,
   output logic                            o_irq
);
   import adc_store_pkg::*;

   // ==========================================================
   // Register state
   logic [7:0]              mode_q;
   logic [2:0]              clksel_q;
   logic                    eoc_q;
   logic [IRQ_W-1:0]        irq_stat_q;
   logic [IRQ_W-1:0]        irq_mask_q;
   logic [RES_W-1:0]        res_q   [NUM_PAIRS];
   logic [NUM_PAIRS-1:0]    rdy_q;
   logic [NUM_PAIRS-1:0]    ovr_q;
   logic [PAIR_W-1:0]       ptr_q;
   logic [PRESC_W-1:0]      presc_q;
   logic                    ack_q;
   logic [31:0]             rdata_q;
   logic                    err_q;
   logic                    done_q;

   logic [1:0]              itm;
   logic                    fixed_rep;
   logic [PAIR_W-1:0]       target;
   logic [PAIR_W-1:0]       last_ptr;
   logic                    group_end;
   logic                    eoc_set;
   logic                    acc;
   logic                    fire_wr;
   logic                    fire_rd;
   logic [7:0]              offs;
   logic                    res_hit;
   logic                    res_low;
   logic [PAIR_W-1:0]       res_idx;
   logic                    mapped;
   logic [PRESC_W-1:0]      presc_mask;

   assign itm       = mode_q[MODE_ITM_LSB +: 2];
   assign fixed_rep = mode_q[MODE_REPEAT_BIT] & ~mode_q[MODE_SCAN_BIT];
   assign o_repeat  = mode_q[MODE_REPEAT_BIT];
   assign o_scan    = mode_q[MODE_SCAN_BIT];

   // ==========================================================
   // Conversion clock prescaler
   // The free counter keeps running so a divider change takes effect
   // at the next natural boundary rather than restarting the period.
   always_comb begin
      unique case (clksel_q)
         3'h0:    presc_mask = 4'h0;
         3'h1:    presc_mask = 4'h1;
         3'h2:    presc_mask = 4'h3;
         3'h3:    presc_mask = 4'h7;
         default: presc_mask = 4'hF;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + 4'h1;
      end
   end

   assign o_conv_clk_en = i_rstn && ((presc_q & presc_mask) == presc_mask);

   // ==========================================================
   // Result routing
   always_comb begin
      unique case (itm)
         ITM_EVERY4: last_ptr = LAST_OF4;
         ITM_EVERY8: last_ptr = LAST_OF8;
         default:    last_ptr = '0;
      endcase
      if (fixed_rep) begin
         // reserved interval code behaves as every conversion
         target = (itm == ITM_EVERY4 || itm == ITM_EVERY8) ? ptr_q : '0;
      end else begin
         target = i_conv_channel[PAIR_W-1:0];
      end
      group_end = (itm == ITM_EVERY4 || itm == ITM_EVERY8) ? (ptr_q == last_ptr)
                                                           : 1'b1;
      eoc_set = i_conv_valid && (fixed_rep ? group_end : i_conv_last);
   end

   // walk pairs of a group in order
   // eight-pair walk uses the same pointer
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ptr_q <= '0;
      end else if (!fixed_rep) begin
         ptr_q <= '0;
      end else if (i_conv_valid) begin
         ptr_q <= group_end ? '0 : ptr_q + 3'h1;
      end
   end

   // ==========================================================
   // APB slave: one wait state so read data comes from a flip-flop
   assign acc     = psel && penable;
   assign pready  = ack_q;
   assign prdata  = rdata_q;
   assign pslverr = err_q;
   assign fire_wr = acc && ack_q && pwrite;
   assign fire_rd = acc && ack_q && !pwrite;
   assign offs    = paddr[7:0];
   assign res_hit = (offs >= OFS_RES_BASE) &&
                    (offs < OFS_RES_BASE + 8'(NUM_PAIRS * RES_STRIDE)) &&
                    (offs[1:0] == 2'b00) && (paddr[31:8] == '0);
   assign res_low = offs[2];
   assign res_idx = 3'((offs - OFS_RES_BASE) >> 3);
   assign mapped  = res_hit || (paddr[31:8] == '0 &&
                    (offs == OFS_MODE || offs == OFS_CLKSEL ||
                     offs == OFS_IRQ_STAT || offs == OFS_IRQ_MASK));

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= acc && !ack_q;
         err_q <= acc && !ack_q && !mapped;
         if (acc && !ack_q && !pwrite) begin
            rdata_q <= '0;
            if (res_hit && !res_low) begin
               rdata_q[7:0] <= res_q[res_idx][RES_W-1 -: 8];
            end else if (res_hit) begin
               rdata_q[LOW_DATA_LSB +: LOW_BITS] <= res_q[res_idx][LOW_BITS-1:0];
               rdata_q[LOW_OVR_BIT] <= ovr_q[res_idx];
               rdata_q[LOW_RDY_BIT] <= rdy_q[res_idx];
            end else if (offs == OFS_MODE) begin
               rdata_q[7:0] <= {eoc_q, mode_q[6:0]};
            end else if (offs == OFS_CLKSEL) begin
               rdata_q[2:0] <= clksel_q;
            end else if (offs == OFS_IRQ_STAT) begin
               rdata_q[IRQ_W-1:0] <= irq_stat_q;
            end else if (offs == OFS_IRQ_MASK) begin
               rdata_q[IRQ_W-1:0] <= irq_mask_q;
            end
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         mode_q     <= MODE_RESET;
         clksel_q   <= DIV_1;
         irq_mask_q <= '0;
      end else if (fire_wr && !err_q) begin
         if (offs == OFS_MODE) begin
            mode_q <= {1'b0, pwdata[6:0]};
         end
         if (offs == OFS_CLKSEL) begin
            clksel_q <= pwdata[2:0];
         end
         if (offs == OFS_IRQ_MASK) begin
            irq_mask_q <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // flag set at the same edge the result lands
   // cleared only if the read actually showed it
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         eoc_q <= 1'b0;
      end else if (eoc_set) begin
         eoc_q <= 1'b1;
      end else if (fire_rd && offs == OFS_MODE && rdata_q[MODE_EOC_BIT]) begin
         eoc_q <= 1'b0;
      end
   end

   // ==========================================================
   // Result pairs; a new store wins over a flag clear by the lower read
   for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
      logic wr_here;
      logic rd_low;
      assign wr_here = i_conv_valid && (target == PAIR_W'(g));
      assign rd_low  = fire_rd && res_hit && res_low && (res_idx == PAIR_W'(g));
      // upper and lower halves held in one word
      always_ff @(posedge i_clk_sys) begin
         if (!i_rstn) begin
            res_q[g] <= '0;
         end else if (wr_here) begin
            res_q[g] <= i_conv_data;
         end
      end
      always_ff @(posedge i_clk_sys) begin
         if (!i_rstn) begin
            rdy_q[g] <= 1'b0;
            ovr_q[g] <= 1'b0;
         end else if (wr_here) begin
            rdy_q[g] <= 1'b1;
            ovr_q[g] <= rdy_q[g] | (ovr_q[g] & ~(rd_low & rdata_q[LOW_OVR_BIT]));
         end else if (rd_low) begin
            if (rdata_q[LOW_RDY_BIT]) begin
               rdy_q[g] <= 1'b0;
            end
            if (rdata_q[LOW_OVR_BIT]) begin
               ovr_q[g] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Interrupts: sticky status, write one to clear, set wins
   logic [IRQ_W-1:0] irq_ev;
   logic             ovr_ev;
   assign ovr_ev = i_conv_valid && rdy_q[target];
   assign irq_ev = {ovr_ev, eoc_set};

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         irq_stat_q <= '0;
         done_q     <= 1'b0;
      end else begin
         done_q <= eoc_set;
         if (fire_wr && offs == OFS_IRQ_STAT && !err_q) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_ev;
         end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
         end
      end
   end

   assign o_conv_done_irq = done_q;
   assign o_irq           = |(irq_stat_q & irq_mask_q);

   // ==========================================================
   // Checks
   property p_div16_gap;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (o_conv_clk_en && clksel_q == DIV_16 && !fire_wr)
         |=> (!o_conv_clk_en || clksel_q < DIV_16) [*8];
   endproperty
   a_div16_gap: assert property (p_div16_gap)
      else $error("conversion clock enable too frequent at divide by 16");

   property p_store_data;
      logic [PAIR_W-1:0] t;
      logic [RES_W-1:0]  d;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid, t = target, d = i_conv_data) |=> (res_q[t] == d && rdy_q[t]);
   endproperty
   a_store_data: assert property (p_store_data)
      else $error("result not held in its pair");

   property p_chan_route;
      logic [PAIR_W-1:0] c;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid && !fixed_rep, c = i_conv_channel[PAIR_W-1:0]) |=> rdy_q[c];
   endproperty
   a_chan_route: assert property (p_chan_route)
      else $error("channel result not in pair channel modulo 8");

   property p_every1_pair0;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid && fixed_rep && itm != ITM_EVERY4 && itm != ITM_EVERY8)
         |=> (rdy_q[0] && res_q[0] == $past(i_conv_data));
   endproperty
   a_every1_pair0: assert property (p_every1_pair0)
      else $error("every-one repeat result not routed to pair 0");

   property p_group4_wrap;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid && fixed_rep && itm == ITM_EVERY4 && ptr_q == LAST_OF4 && !fire_wr)
         |=> (ptr_q == '0 && eoc_q);
   endproperty
   a_group4_wrap: assert property (p_group4_wrap)
      else $error("four-group did not wrap with end flag");

   property p_group8_step;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid && fixed_rep && itm == ITM_EVERY8 && ptr_q != LAST_OF8 && !fire_wr)
         |=> ptr_q == $past(ptr_q) + 3'h1;
   endproperty
   a_group8_step: assert property (p_group8_step)
      else $error("eight-group pointer did not advance by one");

   property p_eoc_after_store;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      $rose(eoc_q) |-> $past(i_conv_valid) && (|rdy_q);
   endproperty
   a_eoc_after_store: assert property (p_eoc_after_store)
      else $error("end flag rose without a stored result");

   property p_ovr_on_rewrite;
      logic [PAIR_W-1:0] t;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (i_conv_valid && rdy_q[target], t = target) |=> ovr_q[t] && irq_stat_q[IRQ_OVR_BIT];
   endproperty
   a_ovr_on_rewrite: assert property (p_ovr_on_rewrite)
      else $error("overwrite of unread result not flagged");

   property p_eoc_read_clear;
      @(posedge i_clk_sys) disable iff (!i_rstn)
      (fire_rd && offs == OFS_MODE && rdata_q[MODE_EOC_BIT] && !eoc_set) |=> !eoc_q;
   endproperty
   a_eoc_read_clear: assert property (p_eoc_read_clear)
      else $error("end flag not cleared by read");

   c_group8: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_conv_valid && fixed_rep && itm == ITM_EVERY8 && ptr_q == LAST_OF8);
   c_overrun: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_conv_valid && rdy_q[target]);
   c_eoc_read: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
      fire_rd && offs == OFS_MODE && rdata_q[MODE_EOC_BIT]);
endmodule

// >>> rtl/adc_store_pkg.sv
/*
 * Constants for the converter result storage and clocking block: register
 * offsets, field positions, reset values and mode encodings.
 * Assumes a 32-bit APB bus and a converter core on the same clock.
 */
package adc_store_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_MODE     = 8'h00;
   localparam logic [7:0] OFS_CLKSEL   = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_RES_BASE = 8'h40;
   localparam int         RES_STRIDE   = 8;
   localparam int         RES_LOW_OFS  = 4;
   localparam int         NUM_PAIRS    = 8;
   localparam int         PAIR_W       = 3;

   // ==========================================================
   // Mode register fields
   localparam int MODE_SCAN_BIT   = 0;
   localparam int MODE_REPEAT_BIT = 1;
   localparam int MODE_ITM_LSB    = 2;
   localparam int MODE_EOC_BIT    = 7;

   // Repeat interrupt interval encodings
   localparam logic [1:0] ITM_EVERY1 = 2'b00;
   localparam logic [1:0] ITM_EVERY4 = 2'b01;
   localparam logic [1:0] ITM_EVERY8 = 2'b10;
   localparam logic [2:0] LAST_OF4   = 3'h3;
   localparam logic [2:0] LAST_OF8   = 3'h7;

   // Conversion clock divider encodings
   localparam logic [2:0] DIV_1  = 3'h0;
   localparam logic [2:0] DIV_16 = 3'h4;
   localparam int         PRESC_W = 4;

   // ==========================================================
   // Result and flag layout
   localparam int RES_W        = 10;
   localparam int LOW_BITS     = 2;
   localparam int LOW_DATA_LSB = 6;
   localparam int LOW_OVR_BIT  = 1;
   localparam int LOW_RDY_BIT  = 0;

   // Interrupt status bits
   localparam int IRQ_EOC_BIT = 0;
   localparam int IRQ_OVR_BIT = 1;
   localparam int IRQ_W       = 2;

   localparam logic [7:0] MODE_RESET = 8'h00;
endpackage

// >>> bench/conv_model.sv
/*
 * Behavioural converter core that hands results to the storage block.
 * Assumes the caller enters send just after a rising edge of the clock.
 */
module conv_model
   import adc_store_pkg::*;
(
   input  wire logic             i_clk_sys,
   output logic                  o_valid,
   output logic [RES_W-1:0]      o_data,
   output logic [4:0]            o_channel,
   output logic                  o_last
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      o_valid = 1'b0;
      o_data = '0;
      o_channel = '0;
      o_last = 1'b0;
   end

   // ==========================================================
   // One result per call
   // Data and channel lines are inverted after the pulse so stale data never looks valid
   task automatic send(input logic [4:0] ch, input logic [RES_W-1:0] d, input logic last);
      o_valid <= 1'b1;
      o_data <= d;
      o_channel <= ch;
      o_last <= last;
      @(posedge i_clk_sys);
      o_valid <= 1'b0;
      o_data <= ~d;
      o_channel <= ~ch;
      o_last <= 1'b0;
      @(posedge i_clk_sys);
   endtask
endmodule

// >>> bench/test_adc_result_storage_clocking.sv
/*
 * Self-checking bench for the result storage block over APB.
 * Assumes the converter model on the far side and a 50 MHz clock.
 */
module test_adc_result_storage_clocking
   import adc_store_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic        pready, pslverr, last_err, cv, clast, clk_en, rep, scan, done_irq, irq;
   logic [9:0]  cdata;
   logic [9:0]  d;
   logic [4:0]  cch;
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;
   int          done_cnt = 0;
   int          n;
   int          chs[4] = '{0, 9, 18, 23};
   int          szs[3] = '{1, 4, 8};
   logic [7:0]  modes[3] = '{8'h02, 8'h06, 8'h0A};

   adc_result_store #(.CHAN_W(5)) i_dut (
      .i_clk_sys(clk), .i_rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .i_conv_valid(cv), .i_conv_data(cdata), .i_conv_channel(cch), .i_conv_last(clast),
      .o_conv_clk_en(clk_en), .o_repeat(rep), .o_scan(scan),
      .o_conv_done_irq(done_irq), .o_irq(irq));

   conv_model i_conv (.i_clk_sys(clk), .o_valid(cv), .o_data(cdata), .o_channel(cch),
      .o_last(clast));

   always #10 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (done_irq === 1'b1) done_cnt <= done_cnt + 1;
   end

   // ==========================================================
   // Tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic eoc(input logic exp);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("end flag", 32'(q[MODE_EOC_BIT]), 32'(exp));
   endtask

   task automatic pair(input int p, input logic [9:0] v, input logic ovr);
      apb(1'b0, 8'(OFS_RES_BASE + p * RES_STRIDE), 32'h0);
      chk("upper", q, {24'h0, v[9:2]});
      apb(1'b0, 8'(OFS_RES_BASE + p * RES_STRIDE + RES_LOW_OFS), 32'h0);
      chk("lower", q, {24'h0, v[1:0], 4'h0, ovr, 1'b1});
   endtask

   initial begin
      wait (cyc == 5000);
      err_total++;
      close_out();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode reset", q, {24'h0, MODE_RESET});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped err", 32'(last_err), 32'h1);
      apb(1'b1, OFS_MODE, 32'h81);
      chk("scan out", 32'(scan), 32'h1);
      eoc(1'b0);
      apb(1'b1, OFS_MODE, 32'h0);
      for (int s = 0; s < 6; s++) begin
         apb(1'b1, OFS_CLKSEL, 32'(s));
         n = 0;
         repeat (32) begin
            @(posedge clk);
            if (clk_en === 1'b1) n++;
         end
         chk("clk enable count", 32'(n), 32'(32 >> (s > 4 ? 4 : s)));
      end
      apb(1'b1, OFS_CLKSEL, 32'h3);
      for (int i = 0; i < 4; i++) begin
         d = 10'(10'h2C5 + 10'(i * 37));
         i_conv.send(5'(chs[i]), d, 1'b1);
         eoc(1'b1);
         eoc(1'b0);
         pair(chs[i] % 8, d, 1'b0);
      end
      i_conv.send(5'd17, 10'h3A6, 1'b0);
      eoc(1'b0);
      i_conv.send(5'd1, 10'h0F3, 1'b1);
      pair(1, 10'h0F3, 1'b1);
      apb(1'b0, 8'(OFS_RES_BASE + RES_STRIDE + RES_LOW_OFS), 32'h0);
      chk("lower cleared", q & 32'h3, 32'h0);
      for (int g = 0; g < 3; g++) begin
         apb(1'b1, OFS_MODE, 32'h0);
         apb(1'b1, OFS_MODE, {24'h0, modes[g]});
         chk("repeat out", 32'(rep), 32'h1);
         for (int i = 0; i < szs[g]; i++) begin
            i_conv.send(5'd5, 10'(10'h111 + 10'(i * 41)), 1'b0);
            if (i == szs[g] - 2) eoc(1'b0);
         end
         eoc(1'b1);
         for (int i = 0; i < szs[g]; i++) pair(i, 10'(10'h111 + 10'(i * 41)), 1'b0);
         i_conv.send(5'd5, 10'h07E, 1'b0);
         pair(0, 10'h07E, 1'b0);
         eoc(g == 0);
      end
      // Reserved interval code from a group mode, then scan repeat routing
      apb(1'b1, OFS_MODE, 32'h0E);
      i_conv.send(5'd3, 10'h1D4, 1'b0);
      eoc(1'b1);
      pair(0, 10'h1D4, 1'b0);
      apb(1'b1, OFS_MODE, 32'h03);
      i_conv.send(5'd12, 10'h2A9, 1'b1);
      eoc(1'b1);
      pair(4, 10'h2A9, 1'b0);
      // Interrupt path: sticky status, mask, write-one-to-clear
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq status", q, 32'h3);
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      chk("irq on", 32'(irq), 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'(irq), 32'h0);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq status left", q, 32'h2);
      apb(1'b1, OFS_IRQ_MASK, 32'h3);
      chk("irq overrun", 32'(irq), 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h2);
      chk("irq idle", 32'(irq), 32'h0);
      chk("done pulses", 32'(done_cnt), 32'd11);
      close_out();
   end
endmodule
